/* rsc_clkout_div.sv */
// Reference clock output divider driven by a crystal-rate enable
`default_nettype none
module rsc_clkout_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Crystal-rate tick and settings
  input wire logic xtal_tick,
  input wire logic enable,
  input wire logic [4:0] divide,
  // Output
  output logic clk_out
);
  logic [4:0] count_reg;
  logic half_reg;
  // ==========================================================================
  // Divider: output toggles every divide ticks, giving xtal / (2 * divide)
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= 5'h00;
      half_reg <= 1'b0;
    end
    else if (!enable)
    begin
      count_reg <= 5'h00;
      half_reg <= 1'b0;
    end
    else if (xtal_tick)
    begin
      if (count_reg >= divide - 5'h01)
      begin
        count_reg <= 5'h00;
        half_reg <= ~half_reg;
      end
      else
      begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end
  // Zero divide passes the crystal tick through; registered for clean timing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clk_out <= 1'b0;
    else if (!enable)
      clk_out <= 1'b0;
    else if (divide == 5'h00)
      clk_out <= xtal_tick;
    else
      clk_out <= half_reg;
  end
endmodule
`default_nettype wire

/* rsc_config_bank.sv */
// Sync, transmit, clock output and packet handler configuration registers
// Functional notes
// RULE_01 - Second sync byte used only when sync length code is not 00
// RULE_02 - Third sync byte used for codes 1x, fourth only for 11
// RULE_03 - Sync length codes 00..11 give 8, 16, 24, 32 bits; 32 at reset
// RULE_04 - Sync error tolerance zero to three bits; zero at reset
// RULE_05 - Transmit bits 7-4 set smoothing filter cutoff; reset 0111
// RULE_06 - Transmit bits 3-1 set power step, 0 is maximum; reset 001
// RULE_07 - Transmit bit 0 selects zero-IF, deviation unused
// RULE_08 - Oscillator bit 7 gates the reference clock pin; enabled at reset
// RULE_09 - Divider field 6-2: zero passes crystal, else divide by twice value
// RULE_10 - Address 28 bit 7 enables Manchester coding; off at reset
// RULE_11 - Length field: exact length fixed, receive maximum variable
// RULE_12 - Eight-bit node address, reset zero, compared when filtering
// RULE_13 - Address 30 bit 7 selects fixed (reset) or variable format
// RULE_14 - Preamble one to four bytes; three at reset
// RULE_15 - Bit 4 enables whitening; off at reset
// RULE_16 - Bit 3 enables CRC generation and check; on at reset
// RULE_17 - Address filter: off, node, plus 0x00, plus 0xFF
// RULE_18 - Address 30 bit 0 is read-only CRC pass flag
// RULE_19 - Address 31 bit 7 clear means auto FIFO clear on CRC failure
// RULE_20 - Address 31 bit 6 sets standby FIFO direction, write at reset
// RULE_21 - Host programs byte registers one address per transfer
// RULE_22 - Host writes reserved bits as zero, never the CRC flag
// RULE_23 - Every field takes its default on reset before any access
`default_nettype none
module rsc_config_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial configuration port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sync recognition settings held in the neighbouring sync control register
  input wire logic [1:0] sync_size,
  input wire logic [1:0] sync_tol,
  // Receive packet events
  input wire logic rx_crc_valid,
  input wire logic rx_crc_pass,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  // Crystal-rate tick for the clock output
  input wire logic xtal_tick,
  // Outputs to datapath and pins
  output rsc_pkg::rsc_cfg_type cfg,
  output logic rx_addr_accept,
  output logic fifo_clear,
  output logic clkout_pin
);
  logic [7:0] sync_reg [4];
  logic [7:0] tx_reg;
  logic [7:0] clk_reg;
  logic [7:0] code_len_reg;
  logic [7:0] node_reg;
  logic [7:0] format_reg;
  logic [7:0] fifo_reg;
  logic crc_ok_reg;
  logic [1:0] sync_size_reg;
  logic [1:0] sync_tol_reg;
  logic clkout_raw;
  logic [3:0] sync_used;
  // ==========================================================================
  // Helpers
  // Byte enables of the sync pattern for a given length code
  function automatic logic [3:0] sync_bytes_used(input logic [1:0] size);
    logic [3:0] used;
    used = 4'h1;
    if (size != 2'h0)
      used[1] = 1'b1; // RULE_01
    if (size[1])
      used[2] = 1'b1; // RULE_02
    if (size == 2'h3)
      used[3] = 1'b1; // RULE_02
    return used;
  endfunction
  // Address filter decision for a received address
  function automatic logic addr_match(input logic [1:0] mode, input logic [7:0] node, input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (mode)
      rsc_pkg::FILT_OFF: hit = 1'b1;
      rsc_pkg::FILT_NODE: hit = (addr == node);
      rsc_pkg::FILT_NODE_ZERO: hit = (addr == node) || (addr == 8'h00);
      default: hit = (addr == node) || (addr == 8'h00) || (addr == 8'hFF);
    endcase
    return hit; // RULE_17
  endfunction
  // ==========================================================================
  // Sync pattern bytes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        sync_reg[i] <= rsc_pkg::RST_SYNC_BYTE; // RULE_23
    end
    else if (reg_wr && reg_addr >= rsc_pkg::ADDR_SYNC_BYTE1 && reg_addr <= rsc_pkg::ADDR_SYNC_BYTE4)
    begin
      sync_reg[2'(reg_addr - rsc_pkg::ADDR_SYNC_BYTE1)] <= reg_wdata; // RULE_21
    end
  end
  // Sync size and tolerance sampled from the sync control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_size_reg <= rsc_pkg::RST_SYNC_SIZE; // RULE_03
      sync_tol_reg <= rsc_pkg::RST_SYNC_TOL; // RULE_04
    end
    else
    begin
      sync_size_reg <= sync_size;
      sync_tol_reg <= sync_tol;
    end
  end
  // ==========================================================================
  // Transmit, clock output and packet registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_reg <= rsc_pkg::RST_TX_SET; // RULE_05
      clk_reg <= rsc_pkg::RST_CLKOUT_SET; // RULE_08
      code_len_reg <= rsc_pkg::RST_PKT_CODE_LEN; // RULE_10
      node_reg <= rsc_pkg::RST_PKT_NODE; // RULE_12
      format_reg <= rsc_pkg::RST_PKT_FORMAT; // RULE_13
      fifo_reg <= rsc_pkg::RST_PKT_FIFO; // RULE_19
    end
    else if (reg_wr)
    begin
      if (reg_addr == rsc_pkg::ADDR_TX_SET)
        tx_reg <= reg_wdata;
      else if (reg_addr == rsc_pkg::ADDR_CLKOUT_SET)
        clk_reg <= reg_wdata & rsc_pkg::MASK_CLKOUT_SET;
      else if (reg_addr == rsc_pkg::ADDR_PKT_CODE_LEN)
        code_len_reg <= reg_wdata;
      else if (reg_addr == rsc_pkg::ADDR_PKT_NODE)
        node_reg <= reg_wdata;
      else if (reg_addr == rsc_pkg::ADDR_PKT_FORMAT)
        format_reg <= reg_wdata & rsc_pkg::MASK_PKT_FORMAT; // RULE_18
      else if (reg_addr == rsc_pkg::ADDR_PKT_FIFO)
        fifo_reg <= reg_wdata & rsc_pkg::MASK_PKT_FIFO;
    end
  end
  // CRC result of the current packet; host writes cannot touch it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      crc_ok_reg <= 1'b0;
    else if (rx_crc_valid)
      crc_ok_reg <= rx_crc_pass; // RULE_18
  end
  // ==========================================================================
  // Read data, registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr >= rsc_pkg::ADDR_SYNC_BYTE1 && reg_addr <= rsc_pkg::ADDR_SYNC_BYTE4)
        reg_rdata <= sync_reg[2'(reg_addr - rsc_pkg::ADDR_SYNC_BYTE1)];
      else if (reg_addr == rsc_pkg::ADDR_TX_SET)
        reg_rdata <= tx_reg;
      else if (reg_addr == rsc_pkg::ADDR_CLKOUT_SET)
        reg_rdata <= clk_reg;
      else if (reg_addr == rsc_pkg::ADDR_PKT_CODE_LEN)
        reg_rdata <= code_len_reg;
      else if (reg_addr == rsc_pkg::ADDR_PKT_NODE)
        reg_rdata <= node_reg;
      else if (reg_addr == rsc_pkg::ADDR_PKT_FORMAT)
        reg_rdata <= {format_reg[7:1], crc_ok_reg}; // RULE_18
      else if (reg_addr == rsc_pkg::ADDR_PKT_FIFO)
        reg_rdata <= fifo_reg;
      else
        reg_rdata <= 8'h00; // Outside this bank
    end
  end
  // Byte enables of the active sync length, named so single bits can be picked
  assign sync_used = sync_bytes_used(sync_size_reg); // RULE_03
  // ==========================================================================
  // Configuration to the datapaths, registered so every output is a flop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg <= '0;
    end
    else
    begin
      cfg.sync_pattern <= {sync_reg[0], sync_reg[1], sync_reg[2], sync_reg[3]};
      cfg.sync_mask <= {{8{sync_used[0]}}, {8{sync_used[1]}}, {8{sync_used[2]}}, {8{sync_used[3]}}}; // RULE_03
      cfg.sync_tol <= sync_tol_reg; // RULE_04
      cfg.tx_smoothing_cutoff <= tx_reg[rsc_pkg::TX_CUTOFF_LSB +: 4]; // RULE_05
      cfg.power_step <= tx_reg[rsc_pkg::TX_POWER_LSB +: 3]; // RULE_06
      cfg.zero_if <= tx_reg[rsc_pkg::TX_ZERO_IF_BIT]; // RULE_07
      cfg.manchester_on <= code_len_reg[rsc_pkg::PKT_MANCH_BIT]; // RULE_10
      cfg.payload_length <= code_len_reg[6:0]; // RULE_11
      cfg.variable_length <= format_reg[rsc_pkg::PKT_FORMAT_BIT]; // RULE_13
      cfg.preamble_bytes <= 3'(format_reg[rsc_pkg::PKT_PREAMBLE_LSB +: 2]) + 3'h1; // RULE_14
      cfg.whitening_on <= format_reg[rsc_pkg::PKT_WHITEN_BIT]; // RULE_15
      cfg.crc_on <= format_reg[rsc_pkg::PKT_CRC_ON_BIT]; // RULE_16
      cfg.fifo_auto_clear <= ~fifo_reg[rsc_pkg::FIFO_AUTOCLR_OFF_BIT]; // RULE_19
      cfg.fifo_stby_read <= fifo_reg[rsc_pkg::FIFO_STBY_READ_BIT]; // RULE_20
    end
  end
  // ==========================================================================
  // Receive address filter, one cycle after the address strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_addr_accept <= 1'b0;
    else if (rx_addr_valid)
      rx_addr_accept <= addr_match(format_reg[rsc_pkg::PKT_FILT_LSB +: 2], node_reg, rx_addr); // RULE_12
  end
  // FIFO clear pulse on CRC failure; only meaningful while CRC checking is on
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fifo_clear <= 1'b0;
    else
      fifo_clear <= rx_crc_valid && !rx_crc_pass && format_reg[rsc_pkg::PKT_CRC_ON_BIT]
                    && !fifo_reg[rsc_pkg::FIFO_AUTOCLR_OFF_BIT]; // RULE_19
  end
  // ==========================================================================
  // Reference clock output
  rsc_clkout_div u_clkout (
    .clk(clk),
    .rst_n(rst_n),
    .xtal_tick(xtal_tick),
    .enable(clk_reg[rsc_pkg::CLK_ON_BIT]), // RULE_08
    .divide(clk_reg[rsc_pkg::CLK_DIV_LSB +: 5]), // RULE_09
    .clk_out(clkout_raw)
  );
  // Extra flop so the pin comes straight from a register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clkout_pin <= 1'b0;
    else
      clkout_pin <= clkout_raw;
  end
endmodule
`default_nettype wire

/* rsc_config_checker.sv */
// Port checker for the packet configuration bank
`default_nettype none
module rsc_config_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Settings and receive events
  input wire logic [1:0] sync_size,
  input wire logic [1:0] sync_tol,
  input wire logic rx_crc_valid,
  input wire logic rx_crc_pass,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  input wire logic xtal_tick,
  // Outputs
  input wire rsc_pkg::rsc_cfg_type cfg,
  input wire logic rx_addr_accept,
  input wire logic fifo_clear,
  input wire logic clkout_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Register port
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr < 5'h16 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_node_readback: assert property (reg_wr && reg_addr == 5'h1D ##2 reg_rd && reg_addr == 5'h1D
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("node address readback wrong");
  // Transmit fields reach cfg one cycle after the register
  chk_tx_fields: assert property (reg_wr && reg_addr == 5'h1A |=> ##1
    {cfg.tx_smoothing_cutoff, cfg.power_step, cfg.zero_if} == $past(reg_wdata, 2)) else $error("tx fields wrong");
  // ==========================================================================
  // Sync settings, judged only once the input has settled
  chk_sync_mask: assert property ($stable(sync_size)[*3] ##0 $past(rst_n, 3) |-> cfg.sync_mask ==
    {8'hFF, {8{sync_size != 2'h0}}, {8{sync_size[1]}}, {8{sync_size == 2'h3}}}) else $error("sync mask wrong");
  chk_sync_tol: assert property ($stable(sync_tol)[*3] ##0 $past(rst_n, 3) |-> cfg.sync_tol == sync_tol)
    else $error("sync tolerance wrong");
  // ==========================================================================
  // Receive events and pins
  chk_clear_fires: assert property (rx_crc_valid && !rx_crc_pass && cfg.crc_on && cfg.fifo_auto_clear
    |=> fifo_clear) else $error("fifo clear missing");
  chk_clear_cause: assert property (fifo_clear |-> $past(rx_crc_valid) && !$past(rx_crc_pass))
    else $error("fifo clear without failed crc");
  chk_clear_pulse: assert property (fifo_clear && !rx_crc_valid |=> !fifo_clear)
    else $error("fifo clear longer than one cycle");
  chk_accept_holds: assert property (!rx_addr_valid |=> $stable(rx_addr_accept))
    else $error("address accept moved without event");
  chk_clkout_off: assert property (reg_wr && reg_addr == 5'h1B && !reg_wdata[7] ##1 !reg_wr[*3]
    |-> !clkout_pin) else $error("clock pin active while disabled");
  // Main scenarios
  cov_clear: cover property (fifo_clear);
  cov_accept: cover property (rx_addr_valid ##1 rx_addr_accept);
  cov_fmt_read: cover property (reg_rd && reg_addr == 5'h1E);
endmodule
`default_nettype wire

/* rsc_host_model.sv */
// Host microcontroller model on the serial configuration port
`default_nettype none
module rsc_host_model (
  // Clock
  input wire logic clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  // One byte per transfer; released lines show the inverse so stale data never looks valid
  task automatic write_byte(input logic [4:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask
  // Read data is taken a cycle after the strobe
  task automatic read_byte(input logic [4:0] addr, output logic [7:0] data);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(posedge clk);
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* rsc_pkg.sv */
// Package of addresses, field positions, reset values and carrier types for the packet configuration bank
`default_nettype none
package rsc_pkg;
  // ==========================================================================
  // Register addresses (byte addresses on the serial configuration port)
  localparam logic [4:0] ADDR_SYNC_BYTE1 = 5'h16;
  localparam logic [4:0] ADDR_SYNC_BYTE2 = 5'h17;
  localparam logic [4:0] ADDR_SYNC_BYTE3 = 5'h18;
  localparam logic [4:0] ADDR_SYNC_BYTE4 = 5'h19;
  localparam logic [4:0] ADDR_TX_SET = 5'h1A;
  localparam logic [4:0] ADDR_CLKOUT_SET = 5'h1B;
  localparam logic [4:0] ADDR_PKT_CODE_LEN = 5'h1C;
  localparam logic [4:0] ADDR_PKT_NODE = 5'h1D;
  localparam logic [4:0] ADDR_PKT_FORMAT = 5'h1E;
  localparam logic [4:0] ADDR_PKT_FIFO = 5'h1F;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_SYNC_BYTE = 8'h00;
  localparam logic [7:0] RST_TX_SET = 8'h72;
  localparam logic [7:0] RST_CLKOUT_SET = 8'hBC;
  localparam logic [7:0] RST_PKT_CODE_LEN = 8'h00;
  localparam logic [7:0] RST_PKT_NODE = 8'h00;
  localparam logic [7:0] RST_PKT_FORMAT = 8'h48;
  localparam logic [7:0] RST_PKT_FIFO = 8'h00;
  localparam logic [1:0] RST_SYNC_SIZE = 2'h3;
  localparam logic [1:0] RST_SYNC_TOL = 2'h0;
  // ==========================================================================
  // Field positions
  localparam int TX_CUTOFF_LSB = 4;
  localparam int TX_POWER_LSB = 1;
  localparam int TX_ZERO_IF_BIT = 0;
  localparam int CLK_ON_BIT = 7;
  localparam int CLK_DIV_LSB = 2;
  localparam int PKT_MANCH_BIT = 7;
  localparam int PKT_FORMAT_BIT = 7;
  localparam int PKT_PREAMBLE_LSB = 5;
  localparam int PKT_WHITEN_BIT = 4;
  localparam int PKT_CRC_ON_BIT = 3;
  localparam int PKT_FILT_LSB = 1;
  localparam int PKT_CRC_OK_BIT = 0;
  localparam int FIFO_AUTOCLR_OFF_BIT = 7;
  localparam int FIFO_STBY_READ_BIT = 6;
  // Writable masks: reserved bits and the CRC result bit are stored as zero on every write
  localparam logic [7:0] MASK_CLKOUT_SET = 8'hFC;
  localparam logic [7:0] MASK_PKT_FORMAT = 8'hFE;
  localparam logic [7:0] MASK_PKT_FIFO = 8'hC0;
  // ==========================================================================
  // Address filter modes
  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_NODE = 2'h1,
    FILT_NODE_ZERO = 2'h2,
    FILT_NODE_ZERO_ONES = 2'h3
  } rsc_filt_type;
  // Configuration handed to the transmit and receive datapaths
  typedef struct packed {
    logic [31:0] sync_pattern;
    logic [31:0] sync_mask;
    logic [1:0] sync_tol;
    logic [3:0] tx_smoothing_cutoff;
    logic [2:0] power_step;
    logic zero_if;
    logic manchester_on;
    logic [6:0] payload_length;
    logic variable_length;
    logic [2:0] preamble_bytes;
    logic whitening_on;
    logic crc_on;
    logic fifo_auto_clear;
    logic fifo_stby_read;
  } rsc_cfg_type;
endpackage
`default_nettype wire

/* tb.sv */
// Self-checking bench for the packet configuration bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [1:0] sync_size = 2'h3;
  logic [1:0] sync_tol = 2'h0;
  logic rx_crc_valid = 1'b0;
  logic rx_crc_pass = 1'b0;
  logic rx_addr_valid = 1'b0;
  logic [7:0] rx_addr = 8'h00;
  logic xtal_tick = 1'b0;
  rsc_pkg::rsc_cfg_type cfg;
  logic rx_addr_accept;
  logic fifo_clear;
  logic clkout_pin;
  logic [7:0] rd_val;
  logic last;
  int edges;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] dflt [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h72, 8'hBC, 8'h00, 8'h00, 8'h48, 8'h00};
  logic [7:0] wmask [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'hFF, 8'hFF, 8'hFE, 8'hC0};
  always #2 clk = ~clk;
  rsc_config_bank rsc_config_bank_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_size(sync_size), .sync_tol(sync_tol),
    .rx_crc_valid(rx_crc_valid), .rx_crc_pass(rx_crc_pass), .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr),
    .xtal_tick(xtal_tick), .cfg(cfg), .rx_addr_accept(rx_addr_accept), .fifo_clear(fifo_clear),
    .clkout_pin(clkout_pin));
  rsc_host_model rsc_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ==========================================================================
  // Compare, access and event tasks
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_reg(input logic [4:0] addr, input logic [7:0] exp);
    rsc_host_model_inst.read_byte(addr, rd_val);
    check_val($sformatf("register %h", addr), {24'h0, exp}, {24'h0, rd_val});
  endtask
  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    rsc_host_model_inst.write_byte(addr, data);
    // Register lands at the write edge, cfg one edge later; look once both have settled
    repeat (2) @(posedge clk);
  endtask
  // Event pulse for one cycle, outcome seen the cycle after it is taken
  task automatic rx_event(input logic crc, input logic [7:0] val, input logic exp);
    @(posedge clk);
    rx_crc_valid <= crc;
    rx_crc_pass <= val[0];
    rx_addr_valid <= !crc;
    rx_addr <= val;
    @(posedge clk);
    rx_crc_valid <= 1'b0;
    rx_addr_valid <= 1'b0;
    rx_addr <= ~val;
    // The clear pulse stands for one cycle only, so look inside it, clear of the edge
    #1;
    check_val(crc ? "fifo clear" : "addr accept", exp, crc ? fifo_clear : rx_addr_accept);
  endtask
  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      check_reg(5'h16 + 5'(i), dflt[i]);
    check_val("sync mask", 32'hFFFFFFFF, cfg.sync_mask);
    check_val("preamble", 32'h3, cfg.preamble_bytes);
    check_val("flags", 32'h30, {cfg.crc_on, cfg.fifo_auto_clear, cfg.whitening_on, cfg.manchester_on,
      cfg.variable_length, cfg.fifo_stby_read});
    // Low nibble set, index in the high nibble; reserved and read-only bits must refuse
    for (int i = 0; i < 10; i++)
      wr(5'h16 + 5'(i), {4'(i), 4'hF});
    for (int i = 0; i < 10; i++)
      check_reg(5'h16 + 5'(i), {4'(i), 4'hF} & wmask[i]);
    wr(5'h05, 8'hFF);
    check_reg(5'h05, 8'h00);
    check_val("sync pattern", 32'h0F1F2F3F, cfg.sync_pattern);
    check_val("length", 32'h6F, {cfg.manchester_on, cfg.payload_length});
    check_val("format", 32'h2, {cfg.variable_length, cfg.fifo_auto_clear});
    for (int p = 0; p < 4; p++)
    begin
      wr(5'h1E, 8'(p << 5) | 8'h18);
      check_val("preamble", p + 1, cfg.preamble_bytes);
      check_val("whitening", 32'h1, cfg.whitening_on);
    end
    for (int s = 0; s < 4; s++)
    begin
      sync_size <= 2'(s);
      sync_tol <= 2'(s);
      repeat (4) @(posedge clk);
      check_val("sync mask", 32'hFFFFFFFF << (8 * (3 - s)), cfg.sync_mask);
      check_val("sync tol", s, cfg.sync_tol);
    end
    // Crc result flag and fifo auto clear, with the clear switched off, on, and crc off
    wr(5'h1E, 8'h68);
    rx_event(1'b1, 8'h00, 1'b0);
    check_reg(5'h1E, 8'h68);
    wr(5'h1F, 8'h00);
    rx_event(1'b1, 8'h01, 1'b0);
    check_reg(5'h1E, 8'h69);
    rx_event(1'b1, 8'h00, 1'b1);
    wr(5'h1E, 8'h60);
    rx_event(1'b1, 8'h00, 1'b0);
    wr(5'h1F, 8'h40);
    check_val("fifo stby", 32'h3, {cfg.fifo_stby_read, cfg.fifo_auto_clear});
    // Address filter, every mode against node, zero, all ones and a stranger
    wr(5'h1D, 8'h5A);
    check_reg(5'h1D, 8'h5A);
    for (int m = 0; m < 4; m++)
    begin
      wr(5'h1E, 8'h08 | 8'(m << 1));
      rx_event(1'b0, 8'h5A, 1'b1);
      rx_event(1'b0, 8'h00, m != 1);
      rx_event(1'b0, 8'hFF, m == 0 || m == 3);
      rx_event(1'b0, 8'h11, m == 0);
    end
    // Reference clock output: divide by two ticks, pass-through, then disabled
    xtal_tick <= 1'b1;
    wr(5'h1B, 8'h88);
    repeat (6) @(posedge clk);
    edges = 0;
    last = clkout_pin;
    repeat (8)
    begin
      @(posedge clk);
      edges += int'(clkout_pin !== last);
      last = clkout_pin;
    end
    check_val("clkout toggles", 4, edges);
    wr(5'h1B, 8'h80);
    repeat (4) @(posedge clk);
    check_val("clkout pass", 32'h1, clkout_pin);
    wr(5'h1B, 8'h08);
    repeat (4) @(posedge clk);
    check_val("clkout off", 32'h0, clkout_pin);
    wrap_up();
  end
endmodule
bind rsc_config_bank rsc_config_checker rsc_config_checker_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_size(sync_size),
  .sync_tol(sync_tol), .rx_crc_valid(rx_crc_valid), .rx_crc_pass(rx_crc_pass), .rx_addr_valid(rx_addr_valid),
  .rx_addr(rx_addr), .xtal_tick(xtal_tick), .cfg(cfg), .rx_addr_accept(rx_addr_accept), .fifo_clear(fifo_clear),
  .clkout_pin(clkout_pin));
`default_nettype wire
